// ===== hw/ready_wait_map.svh
// Constants for the ready-controlled wait-state sequencer
`ifndef READY_WAIT_MAP_SVH
`define READY_WAIT_MAP_SVH

// ---------------------------------------------
// Phase field widths and legal ranges
// ---------------------------------------------
`define RW_SETUP_W 2
`define RW_CMD_W 2
`define RW_ACC_W 6
`define RW_HOLD_W 2
`define RW_SETUP_MIN 6'h01
`define RW_ACC_MIN 6'h01
`define RW_CNT_ZERO 6'h00
`define RW_CNT_ONE 6'h01

// ---------------------------------------------
// Ready input synchroniser depths
// ---------------------------------------------
`define RW_PIN_SYNC_STAGES 2
`define RW_ASYNC_EXTRA_STAGES 1

`endif

// ===== hw/ready_wait_pkg.sv
// Types for the ready-controlled wait-state sequencer
`include "ready_wait_map.svh"

package ready_wait_pkg;

    // ---------------------------------------------
    // Per-cycle programming
    // ---------------------------------------------
    typedef struct packed {
        logic ready_en;
        logic ready_async;
        logic ready_high;
        logic [`RW_SETUP_W-1:0] setup_len;
        logic [`RW_CMD_W-1:0] cmd_delay;
        logic [`RW_ACC_W-1:0] access_phase_length;
        logic [`RW_HOLD_W-1:0] hold_len;
    } cycle_cfg_s;

    // ---------------------------------------------
    // Bus cycle phases
    // ---------------------------------------------
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_SETUP = 3'b001,
        PH_CMD_DELAY = 3'b010,
        PH_ACCESS = 3'b011,
        PH_READY_WAIT = 3'b100,
        PH_HOLD = 3'b101
    } phase_e;

endpackage : ready_wait_pkg

// ===== hw/ready_wait_ctrl.sv
// Bus cycle sequencer with ready-controlled wait states
`timescale 1ns/1ps
`include "ready_wait_map.svh"

module ready_wait_ctrl (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic START,
    input wire ready_wait_pkg::cycle_cfg_s CFG,
    input wire logic READY_PIN,
    output logic CYCLE_BUSY,
    output logic CMD_N,
    output logic READY_WAIT,
    output logic CYCLE_DONE
);
    import ready_wait_pkg::*;

    // ---------------------------------------------
    // Ready synchronisers
    // ---------------------------------------------
    // Pin always gets two flops; asynchronous mode reads one stage further,
    // trading one wait state for safe sampling of an unrelated edge.
    logic ready_s1_q;
    logic ready_s2_q;
    logic ready_s3_q;
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            ready_s1_q <= 1'b0;
            ready_s2_q <= 1'b0;
            ready_s3_q <= 1'b0;
        end else begin
            ready_s1_q <= READY_PIN;
            ready_s2_q <= ready_s1_q;
            ready_s3_q <= ready_s2_q;
        end
    end

    cycle_cfg_s cfg_q;
    phase_e state_q, state_d;
    logic [`RW_ACC_W-1:0] cnt_q, cnt_d;
    logic ready_sync_act;
    logic ready_async_act;
    logic ready_act;

    assign ready_sync_act = ready_s2_q ^ ~cfg_q.ready_high;
    assign ready_async_act = ready_s3_q ^ ~cfg_q.ready_high;
    assign ready_act = cfg_q.ready_async ? ready_async_act : ready_sync_act;

    // ---------------------------------------------
    // Cycle programming latch
    // ---------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            cfg_q <= '0;
        end else if (state_q == PH_IDLE && START) begin
            cfg_q <= CFG;
        end
    end

    function automatic logic [`RW_ACC_W-1:0] len_m1(input logic [`RW_ACC_W-1:0] len,
                                                   input logic [`RW_ACC_W-1:0] lo);
        logic [`RW_ACC_W-1:0] v;
        v = (len < lo) ? lo : len;
        return v - `RW_CNT_ONE;
    endfunction : len_m1

    // ---------------------------------------------
    // Phase sequencing
    // ---------------------------------------------
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            PH_IDLE: begin
                // Ready is not looked at here, leftovers have no effect
                if (START) begin
                    state_d = PH_SETUP;
                    cnt_d = len_m1({{(`RW_ACC_W-`RW_SETUP_W){1'b0}}, CFG.setup_len},
                                   `RW_SETUP_MIN);
                end
            end
            PH_SETUP: begin
                if (cnt_q != `RW_CNT_ZERO) begin
                    cnt_d = cnt_q - `RW_CNT_ONE;
                end else if (cfg_q.cmd_delay != '0) begin
                    state_d = PH_CMD_DELAY;
                    cnt_d = {{(`RW_ACC_W-`RW_CMD_W){1'b0}}, cfg_q.cmd_delay} - `RW_CNT_ONE;
                end else begin
                    state_d = PH_ACCESS;
                    cnt_d = len_m1(cfg_q.access_phase_length, `RW_ACC_MIN);
                end
            end
            PH_CMD_DELAY: begin
                if (cnt_q != `RW_CNT_ZERO) begin
                    cnt_d = cnt_q - `RW_CNT_ONE;
                end else begin
                    state_d = PH_ACCESS;
                    cnt_d = len_m1(cfg_q.access_phase_length, `RW_ACC_MIN);
                end
            end
            PH_ACCESS: begin
                // Mandatory waitstates run out before ready is consulted
                if (cnt_q != `RW_CNT_ZERO) begin
                    cnt_d = cnt_q - `RW_CNT_ONE;
                end else if (!cfg_q.ready_en || (!cfg_q.ready_async && ready_sync_act)) begin
                    state_d = (cfg_q.hold_len != '0) ? PH_HOLD : PH_IDLE;
                    cnt_d = {{(`RW_ACC_W-`RW_HOLD_W){1'b0}}, cfg_q.hold_len} - `RW_CNT_ONE;
                end else begin
                    state_d = PH_READY_WAIT;
                end
            end
            PH_READY_WAIT: begin
                if (ready_act) begin
                    state_d = (cfg_q.hold_len != '0) ? PH_HOLD : PH_IDLE;
                    cnt_d = {{(`RW_ACC_W-`RW_HOLD_W){1'b0}}, cfg_q.hold_len} - `RW_CNT_ONE;
                end
            end
            PH_HOLD: begin
                if (cnt_q != `RW_CNT_ZERO) begin
                    cnt_d = cnt_q - `RW_CNT_ONE;
                end else begin
                    state_d = PH_IDLE;
                end
            end
            default: begin
                state_d = PH_IDLE;
                cnt_d = `RW_CNT_ZERO;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            state_q <= PH_IDLE;
            cnt_q <= `RW_CNT_ZERO;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // ---------------------------------------------
    // Registered outputs
    // ---------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            CYCLE_BUSY <= 1'b0;
            CMD_N <= 1'b1;
            READY_WAIT <= 1'b0;
            CYCLE_DONE <= 1'b0;
        end else begin
            CYCLE_BUSY <= (state_d != PH_IDLE);
            CMD_N <= !(state_d == PH_ACCESS || state_d == PH_READY_WAIT);
            READY_WAIT <= (state_d == PH_READY_WAIT);
            CYCLE_DONE <= (state_d == PH_IDLE) && (state_q != PH_IDLE);
        end
    end

    // ---------------------------------------------
    // Checks
    // ---------------------------------------------
    property p_polarity_end;
        @(posedge CLK) disable iff (!RSTN)
        (state_q == PH_READY_WAIT && !cfg_q.ready_async && ((ready_s2_q == cfg_q.ready_high)))
        |=> (state_q != PH_READY_WAIT);
    endproperty
    a_polarity_end: assert property (p_polarity_end) else $error("ready wait not ended");

    property p_sync_no_wait;
        @(posedge CLK) disable iff (!RSTN)
        (state_q == PH_ACCESS && cnt_q == `RW_CNT_ZERO && cfg_q.ready_en
         && !cfg_q.ready_async && ready_sync_act) |=> !READY_WAIT && CMD_N;
    endproperty
    a_sync_no_wait: assert property (p_sync_no_wait) else $error("sync ready waited");

    property p_async_one_wait;
        @(posedge CLK) disable iff (!RSTN)
        (state_q == PH_ACCESS && cnt_q == `RW_CNT_ZERO && cfg_q.ready_en && cfg_q.ready_async)
        |=> READY_WAIT && state_q == PH_READY_WAIT;
    endproperty
    a_async_one_wait: assert property (p_async_one_wait) else $error("async ready no wait");

    property p_access_load;
        @(posedge CLK) disable iff (!RSTN)
        (state_q != PH_ACCESS && state_d == PH_ACCESS)
        |=> (cnt_q == len_m1(cfg_q.access_phase_length, `RW_ACC_MIN)) && !CMD_N;
    endproperty
    a_access_load: assert property (p_access_load) else $error("access length wrong");

    property p_wait_again;
        @(posedge CLK) disable iff (!RSTN)
        (state_q == PH_READY_WAIT && !ready_act) |=> READY_WAIT ##0 state_q == PH_READY_WAIT;
    endproperty
    a_wait_again: assert property (p_wait_again) else $error("waitstate not inserted");

    property p_ready_done;
        @(posedge CLK) disable iff (!RSTN)
        (state_q == PH_READY_WAIT && ready_act) |=> CMD_N ##[0:3] CYCLE_DONE;
    endproperty
    a_ready_done: assert property (p_ready_done) else $error("cycle not closed");

    property p_mandatory_first;
        @(posedge CLK) disable iff (!RSTN)
        (state_q == PH_ACCESS && cnt_q != `RW_CNT_ZERO) |=> state_q == PH_ACCESS;
    endproperty
    a_mandatory_first: assert property (p_mandatory_first) else $error("ready used early");

    property p_idle_ignore;
        @(posedge CLK) disable iff (!RSTN)
        (state_q == PH_IDLE && !START) |=> $stable(cfg_q) && !CYCLE_BUSY;
    endproperty
    a_idle_ignore: assert property (p_idle_ignore) else $error("idle left without start");

endmodule : ready_wait_ctrl

// ===== dv/ready_source.sv
// Behavioural external circuit that drives the ready pin
`timescale 1ns/1ps

module ready_source (
    input wire logic CLK,
    input wire logic ENABLE,
    input wire logic ACTIVE_HIGH,
    input wire logic [7:0] DELAY,
    input wire logic CMD_N,
    output logic READY_PIN
);
    logic [7:0] low_cnt_q;
    logic cmd_n_q;
    logic spent_q;
    logic trail;

    initial begin
        low_cnt_q = 8'h00;
        cmd_n_q = 1'b1;
        spent_q = 1'b0;
        READY_PIN = 1'b0;
    end

    assign trail = CMD_N && !cmd_n_q;

    // ---------------------------------------------
    // Pin driver
    // ---------------------------------------------
    // Changes only at clock edges, so every level lasts whole periods
    always @(posedge CLK) begin
        cmd_n_q <= CMD_N;
        low_cnt_q <= CMD_N ? 8'h00 : low_cnt_q + 8'h01;
        // Stays inactive until re-armed, so no level leaks into the next cycle
        if (!ENABLE) begin
            spent_q <= 1'b0;
        end else if (trail) begin
            spent_q <= 1'b1;
        end
        if (ENABLE && !spent_q && !trail && low_cnt_q >= DELAY) begin
            READY_PIN <= ACTIVE_HIGH;
        end else begin
            READY_PIN <= ~ACTIVE_HIGH;
        end
    end
endmodule : ready_source

// ===== dv/ready_wait_ctrl_tb.sv
// Self-checking bench for the ready-controlled wait-state sequencer
`timescale 1ns/1ps

module ready_wait_ctrl_tb;
    import ready_wait_pkg::*;

    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic start = 1'b0;
    cycle_cfg_s cfg = '0;
    logic ready_pin;
    logic cycle_busy;
    logic cmd_n;
    logic ready_wait;
    logic cycle_done;
    logic en = 1'b0;
    logic pol = 1'b1;
    logic [7:0] dly = 8'h00;
    int error_cnt = 0;
    int tests_run = 0;

    ready_wait_ctrl DUT (.CLK(clk), .RSTN(rstn), .START(start), .CFG(cfg),
        .READY_PIN(ready_pin), .CYCLE_BUSY(cycle_busy), .CMD_N(cmd_n),
        .READY_WAIT(ready_wait), .CYCLE_DONE(cycle_done));
    ready_source partner (.CLK(clk), .ENABLE(en), .ACTIVE_HIGH(pol), .DELAY(dly),
        .CMD_N(cmd_n), .READY_PIN(ready_pin));

    initial begin
        forever #20 clk = ~clk;
    end

    // ---------------------------------------------
    // Shared tasks
    // ---------------------------------------------
    task automatic finish_test();
        $display("error_cnt %0d tests_run %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Four idle cycles let the two or three synchroniser flops settle
    task automatic prep(input logic e, input logic p, input logic [7:0] d);
        @(posedge clk);
        en <= 1'b0;
        @(posedge clk);
        en <= e;
        pol <= p;
        dly <= d;
        repeat (4) @(posedge clk);
    endtask : prep

    task automatic run_cycle(input cycle_cfg_s c, output int tc, output int nc,
                             output int nw, output int td);
        @(posedge clk);
        start <= 1'b1;
        cfg <= c;
        @(posedge clk);
        start <= 1'b0;
        tc = 0;
        nc = 0;
        nw = 0;
        td = 0;
        for (int k = 1; k <= 300 && td == 0; k++) begin
            @(posedge clk);
            #1;
            if (cmd_n === 1'b0) begin
                if (nc == 0) tc = k;
                nc++;
            end
            if (ready_wait === 1'b1) nw++;
            if (k == 1) chk(cycle_busy, 1'b1);
            if (cycle_done === 1'b1) begin
                td = k;
                chk(cycle_busy, 1'b0);
            end
        end
        if (td == 0) begin
            error_cnt++;
            finish_test();
        end
    endtask : run_cycle

    // ---------------------------------------------
    // Scenarios
    // ---------------------------------------------
    task automatic t_plain();
        cycle_cfg_s c;
        int tc, nc, nw, td;
        c = '0;
        c.cmd_delay = 2'h2;
        c.hold_len = 2'h3;
        for (int e = 0; e < 2; e++) begin
            prep(e[0], 1'b1, 8'h00);
            run_cycle(c, tc, nc, nw, td);
            chk(tc, 3);
            chk(nw, 0);
            chk(nc, 1);
            chk(td, 7);
        end
    endtask : t_plain

    task automatic t_early();
        cycle_cfg_s c;
        int tc, nc, nw, td;
        c = '0;
        c.ready_en = 1'b1;
        c.setup_len = 2'h2;
        c.cmd_delay = 2'h1;
        c.access_phase_length = 6'h04;
        c.hold_len = 2'h1;
        for (int i = 0; i < 4; i++) begin
            c.ready_high = i[0];
            c.ready_async = i[1];
            prep(1'b1, i[0], 8'h00);
            run_cycle(c, tc, nc, nw, td);
            chk(nw, i[1]);
            chk(tc, 3);
            chk(nc, 4 + i[1]);
            chk(td, 8 + i[1]);
        end
    endtask : t_early

    task automatic t_late();
        cycle_cfg_s c;
        int tc, nc, nw, td;
        c = '0;
        c.ready_en = 1'b1;
        c.setup_len = 2'h1;
        c.access_phase_length = 6'h02;
        for (int a = 0; a < 2; a++) begin
            c.ready_async = a[0];
            prep(1'b1, 1'b0, 8'h0c);
            run_cycle(c, tc, nc, nw, td);
            // Delay of 12 plus partner flop, two sync flops and the state flop, less two access cycles; one more in async
            chk(nw, 14 + a);
            chk(nc, 2 + nw);
            chk(td, 3 + nw);
        end
    endtask : t_late

    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        t_plain();
        t_early();
        t_late();
        finish_test();
    end
endmodule : ready_wait_ctrl_tb
